// [src/tx_queue_pkg.sv]
// Constants and carriers for the transmit queue state table.
// Assumes one table instance per queue, word-aligned AHB-Lite offsets.
package tx_queue_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CELL_COUNT = 8'h00;
   localparam logic [7:0] OFS_HEAD_ONE_TWO = 8'h04;
   localparam logic [7:0] OFS_HEAD_THREE_FOUR = 8'h08;
   localparam logic [7:0] OFS_HEAD_FIVE = 8'h0C;
   localparam logic [7:0] OFS_CREDIT = 8'h10;
   localparam logic [7:0] OFS_SCHED_CONFIG = 8'h14;
   localparam logic [7:0] OFS_ALLOC_LOW = 8'h18;
   localparam logic [7:0] OFS_ALLOC_HIGH = 8'h1C;
   localparam logic [7:0] OFS_LEFT_LOW = 8'h20;
   localparam logic [7:0] OFS_LEFT_HIGH = 8'h24;
   localparam logic [7:0] OFS_MODE = 8'h28;

   // Field positions and widths
   localparam int BYTE_HI_LSB = 8;
   localparam int REM_LSB = 14;
   localparam int COUNT_LSB = 10;
   localparam int MODE_W = 2;

   // Values
   localparam logic [15:0] CELL_COUNT_STEP = 16'h0001;
   localparam logic [9:0] CREDIT_MAX = 10'h3FF;
   localparam logic [9:0] HS_PAYLOAD_EIGHTHS = 10'h178;
   localparam logic [5:0] FULL_LINE_SLOTS = 6'h20;
   localparam logic [31:0] SLOT_ONE = 32'h0000_0001;
   localparam int LINE_QUEUES = 32;

   typedef enum logic [1:0] {
      MODE_STRUCT_FRAME = 2'b00,
      MODE_STRUCT_MULTIFRAME = 2'b01,
      MODE_UNSTRUCT_MULTI_LINE = 2'b10,
      MODE_UNSTRUCT_HIGH_SPEED = 2'b11
   } line_mode_t;

   // Scheduler to table
   typedef struct packed {
      logic cell_sent;
      logic credit_valid;
      logic [9:0] credit_add;
      logic [5:0] frame_diff;
      logic byte_take;
      logic [4:0] take_slot;
   } sched_req_t;

   // Table to scheduler
   typedef struct packed {
      logic [15:0] cell_count;
      logic [39:0] header;
      logic [1:0] remainder;
      logic [9:0] credits;
      logic [2:0] mf_eighths;
      logic [5:0] slot_count;
      logic [9:0] avg_payload;
      logic [31:0] alloc;
      logic [31:0] left;
      logic [2:0] line;
   } sched_view_t;

   typedef struct packed {
      logic [15:0] cell_count;
      logic [15:0] head_one_two;
      logic [15:0] head_three_four;
      logic [7:0] head_five;
      logic [1:0] remainder;
      logic [9:0] credits;
      logic [2:0] mf_eighths;
      logic [5:0] slot_count;
      logic [9:0] avg_payload;
      logic [31:0] alloc;
      logic [31:0] left;
      line_mode_t mode;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
   } table_state_t;

endpackage : tx_queue_pkg

// [src/frame_eighths.sv]
// Converts a frame differential plus carried remainder to multiframe
// eighths. Pure combinational; the caller registers the results.
`timescale 1ns/1ps
`default_nettype none
module frame_eighths #(
   parameter int FRAMES_PER_EIGHTH = 2
) (
   input wire logic [1:0] rem_in,
   input wire logic [5:0] frames,
   output logic [2:0] eighths,
   output logic [1:0] rem_out
);
   logic [6:0] total;

   always_comb begin
      total = {5'h00, rem_in} + {1'h0, frames};
      eighths = 3'((total / 7'(FRAMES_PER_EIGHTH)) & 7'h07);
      rem_out = 2'(total % 7'(FRAMES_PER_EIGHTH));
   end
endmodule : frame_eighths
`default_nettype wire

// [src/tx_queue_state_table.sv]
// Transmit queue state words for one queue, reached over AHB-Lite.
// Assumes the cell scheduler drives sched_req synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module tx_queue_state_table
   import tx_queue_pkg::*;
#(
   parameter int QUEUE_NUMBER = 0,
   parameter int FRAMES_PER_EIGHTH = 2
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire sched_req_t sched_req,
   output sched_view_t sched_view
);

   table_state_t q;
   table_state_t d;
   logic [2:0] eighths_new;
   logic [1:0] rem_new;
   logic addr_phase;
   logic unstructured;
   logic [11:0] credit_sum;
   logic [9:0] payload;
   logic [31:0] left_cut;

   localparam logic [2:0] LINE_NUMBER = 3'(QUEUE_NUMBER / LINE_QUEUES);

   frame_eighths #(
      .FRAMES_PER_EIGHTH(FRAMES_PER_EIGHTH)
   ) u_frame_eighths (
      .rem_in(q.remainder),
      .frames(sched_req.frame_diff),
      .eighths(eighths_new),
      .rem_out(rem_new)
   );

   // Word read view; unused bits read as zero
   function automatic logic [31:0] read_word(input table_state_t s,
                                             input logic [7:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (a == OFS_CELL_COUNT) begin
         w[15:0] = s.cell_count;
      end else if (a == OFS_HEAD_ONE_TWO) begin
         w[15:0] = s.head_one_two;
      end else if (a == OFS_HEAD_THREE_FOUR) begin
         w[15:0] = s.head_three_four;
      end else if (a == OFS_HEAD_FIVE) begin
         w[15:BYTE_HI_LSB] = s.head_five;
      end else if (a == OFS_CREDIT) begin
         w[15:REM_LSB] = s.remainder;
         w[9:0] = s.credits;
      end else if (a == OFS_SCHED_CONFIG) begin
         w[15:COUNT_LSB] = s.slot_count;
         w[9:0] = s.avg_payload;
      end else if (a == OFS_ALLOC_LOW) begin
         w[15:0] = s.alloc[15:0];
      end else if (a == OFS_ALLOC_HIGH) begin
         w[15:0] = s.alloc[31:16];
      end else if (a == OFS_LEFT_LOW) begin
         w[15:0] = s.left[15:0];
      end else if (a == OFS_LEFT_HIGH) begin
         w[15:0] = s.left[31:16];
      end else if (a == OFS_MODE) begin
         w[MODE_W-1:0] = s.mode;
      end
      return w;
   endfunction : read_word

   assign addr_phase = hsel && htrans[1] && hready;
   assign unstructured = (q.mode == MODE_UNSTRUCT_MULTI_LINE) ||
                         (q.mode == MODE_UNSTRUCT_HIGH_SPEED);

   always_comb begin
      d = q;
      credit_sum = 12'h000;
      left_cut = q.left;
      // High-speed ignores the programmed average
      payload = (q.mode == MODE_UNSTRUCT_HIGH_SPEED) ?
                HS_PAYLOAD_EIGHTHS : q.avg_payload;

      if (sched_req.cell_sent) begin
         d.cell_count = q.cell_count + CELL_COUNT_STEP;
      end

      // Credits: add earned, subtract one cell, clamp both ends
      credit_sum = {2'h0, q.credits};
      if (sched_req.credit_valid) begin
         credit_sum = credit_sum + {2'h0, sched_req.credit_add};
         d.remainder = rem_new;
         d.mf_eighths = eighths_new;
      end
      if (sched_req.cell_sent) begin
         if (credit_sum > {2'h0, payload}) begin
            credit_sum = credit_sum - {2'h0, payload};
         end else begin
            credit_sum = 12'h000;
         end
      end
      if (credit_sum > {2'h0, CREDIT_MAX}) begin
         d.credits = CREDIT_MAX;
      end else begin
         d.credits = credit_sum[9:0];
      end

      // Gathered timeslot leaves the remaining map
      if (sched_req.byte_take) begin
         left_cut = q.left & ~(SLOT_ONE << sched_req.take_slot);
         if (left_cut == 32'h0000_0000) begin
            d.left = q.alloc;
         end else begin
            d.left = left_cut;
         end
      end

      // Bus data phase; a write overrides a same-cycle hardware update
      if (q.wr_pend) begin
         if (q.wr_addr == OFS_CELL_COUNT) begin
            d.cell_count = hwdata[15:0];
         end else if (q.wr_addr == OFS_HEAD_ONE_TWO) begin
            d.head_one_two = hwdata[15:0];
         end else if (q.wr_addr == OFS_HEAD_THREE_FOUR) begin
            d.head_three_four = hwdata[15:0];
         end else if (q.wr_addr == OFS_HEAD_FIVE) begin
            d.head_five = hwdata[15:BYTE_HI_LSB];
         end else if (q.wr_addr == OFS_CREDIT) begin
            d.remainder = hwdata[15:REM_LSB];
            d.credits = hwdata[9:0];
         end else if (q.wr_addr == OFS_SCHED_CONFIG) begin
            d.slot_count = hwdata[15:COUNT_LSB];
            d.avg_payload = hwdata[9:0];
         end else if (q.wr_addr == OFS_ALLOC_LOW) begin
            d.alloc[15:0] = hwdata[15:0];
         end else if (q.wr_addr == OFS_ALLOC_HIGH) begin
            d.alloc[31:16] = hwdata[15:0];
         end else if (q.wr_addr == OFS_LEFT_LOW) begin
            d.left[15:0] = hwdata[15:0];
         end else if (q.wr_addr == OFS_LEFT_HIGH) begin
            d.left[31:16] = hwdata[15:0];
         end else if (q.wr_addr == OFS_MODE) begin
            d.mode = line_mode_t'(hwdata[MODE_W-1:0]);
         end
      end

      // Bus address phase; read data is ready for the data phase
      d.wr_pend = 1'b0;
      if (addr_phase) begin
         d.wr_pend = hwrite;
         d.wr_addr = {haddr[7:2], 2'b00};
         if (!hwrite) begin
            d.rdata = read_word(q, {haddr[7:2], 2'b00});
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Zero-wait slave; every access answers OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;

   always_comb begin
      sched_view.cell_count = q.cell_count;
      sched_view.header = {q.head_one_two, q.head_three_four,
                           q.head_five};
      sched_view.remainder = q.remainder;
      sched_view.credits = q.credits;
      sched_view.mf_eighths = q.mf_eighths;
      // Unstructured modes serve the whole line
      sched_view.slot_count = unstructured ?
                              FULL_LINE_SLOTS : q.slot_count;
      sched_view.avg_payload = q.avg_payload;
      sched_view.alloc = q.alloc;
      sched_view.left = q.left;
      sched_view.line = LINE_NUMBER;
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // A write landing in the same cycle would make the read see old data
   sequence head_five_read;
      addr_phase && !hwrite && !q.wr_pend &&
         ({haddr[7:2], 2'b00} == OFS_HEAD_FIVE);
   endsequence

   sequence slot_emptied;
      sched_req.byte_take && !q.wr_pend &&
         ((q.left & ~(SLOT_ONE << sched_req.take_slot)) == 32'h0000_0000);
   endsequence

   cell_count_wrap_a: assert property (
      sched_req.cell_sent && !q.wr_pend
      |=> q.cell_count == $past(q.cell_count) + CELL_COUNT_STEP)
      else $error("cell counter did not step by one");

   header_order_a: assert property (
      q.wr_pend && q.wr_addr == OFS_HEAD_ONE_TWO
      |=> sched_view.header[39:32] == $past(hwdata[15:8]) &&
          sched_view.header[31:24] == $past(hwdata[7:0]))
      else $error("header bytes one and two misplaced");

   header_three_four_a: assert property (
      q.wr_pend && q.wr_addr == OFS_HEAD_THREE_FOUR
      |=> sched_view.header[23:8] == $past(hwdata[15:0]))
      else $error("header bytes three and four not written");

   head_five_read_a: assert property (
      head_five_read
      |=> hrdata[7:0] == 8'h00 && hrdata[15:8] == q.head_five)
      else $error("fifth header byte read wrong");

   remainder_range_a: assert property (
      sched_req.credit_valid && !q.wr_pend
      |=> q.remainder < 2'(FRAMES_PER_EIGHTH))
      else $error("remainder out of range");

   credit_grow_a: assert property (
      sched_req.credit_valid && !sched_req.cell_sent && !q.wr_pend
      |=> q.credits >= $past(q.credits))
      else $error("credits fell while earning");

   slot_count_ignored_a: assert property (
      unstructured |-> sched_view.slot_count == FULL_LINE_SLOTS)
      else $error("timeslot count used in unstructured mode");

   hs_payload_a: assert property (
      q.mode == MODE_UNSTRUCT_HIGH_SPEED && sched_req.cell_sent &&
      !sched_req.credit_valid && !q.wr_pend &&
      q.credits > HS_PAYLOAD_EIGHTHS
      |=> q.credits == $past(q.credits) - HS_PAYLOAD_EIGHTHS)
      else $error("high-speed cell cost wrong");

   slot_clear_a: assert property (
      sched_req.byte_take && !q.wr_pend && q.left[sched_req.take_slot]
      |=> !q.left[$past(sched_req.take_slot)] ||
          q.left == $past(q.alloc))
      else $error("taken timeslot stayed in remaining map");

   slot_reload_a: assert property (
      slot_emptied |=> q.left == $past(q.alloc) ##1 q.left != 32'h0 ||
                       q.alloc == 32'h0)
      else $error("remaining map not reloaded");

endmodule : tx_queue_state_table
`default_nettype wire

// [testbench/tx_queue_state_table_tb.sv]
// Self-checking bench for the transmit queue state table.
// Assumes the bench is the only AHB-Lite master and drives the scheduler.
`timescale 1ns/1ps
`default_nettype none
module tx_queue_state_table_tb import tx_queue_pkg::*;;
   localparam int QN = 70;
   logic sys_clk;
   logic rst;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   sched_req_t req;
   sched_view_t view;
   int miscompares = 0;
   int total_checks = 0;

   tx_queue_state_table #(.QUEUE_NUMBER(QN), .FRAMES_PER_EIGHTH(2))
   u_tx_queue_state_table (
      .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .sched_req(req), .sched_view(view));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic stop_test();
      if (miscompares == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One transfer; the master holds each phase until hready is seen high
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0000_0000;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      q = hrdata;
      hsel <= 1'b0;
      chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
      #1;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask : wr

   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0000_0000, q);
      chk(what, exp, q);
   endtask : rd_chk

   // Pulse for one cycle; the view has updated after the next edge
   task automatic pulse(input sched_req_t r);
      @(posedge sys_clk);
      req <= r;
      @(posedge sys_clk);
      req <= '0;
      #1;
   endtask : pulse

   task automatic t_reset_unmapped();
      rd_chk("credit after reset", OFS_CREDIT, 32'h0000_0000);
      wr(8'h2C, 32'h0000_1234);
      rd_chk("unmapped word", 8'h2C, 32'h0000_0000);
   endtask : t_reset_unmapped

   task automatic t_header();
      wr(OFS_HEAD_ONE_TWO, 32'h0000_1122);
      wr(OFS_HEAD_THREE_FOUR, 32'h0000_3344);
      wr(OFS_HEAD_FIVE, 32'h0000_5500);
      chk("header", 32'h2233_4455, view.header[31:0]);
      chk("byte one", 32'h0000_0011, {24'h0, view.header[39:32]});
      rd_chk("head one two", OFS_HEAD_ONE_TWO, 32'h0000_1122);
      rd_chk("head five", OFS_HEAD_FIVE, 32'h0000_5500);
   endtask : t_header

   task automatic t_counter();
      sched_req_t r;
      r = '0;
      r.cell_sent = 1'b1;
      wr(OFS_CELL_COUNT, 32'h0000_0000);
      // Software could preload near the top; this counts all the way up from zero
      @(posedge sys_clk);
      req <= r;
      repeat (16'hFFFF) @(posedge sys_clk);
      req <= '0;
      #1;
      chk("count at top", 32'h0000_FFFF, {16'h0, view.cell_count});
      pulse(r);
      rd_chk("count wrapped", OFS_CELL_COUNT, 32'h0000_0000);
      pulse(r);
      chk("count one", 32'h0000_0001, {16'h0, view.cell_count});
   endtask : t_counter

   task automatic t_credits();
      sched_req_t r;
      wr(OFS_CREDIT, 32'h0000_0177);
      wr(OFS_SCHED_CONFIG, 32'h0000_1D77);
      r = '0;
      r.cell_sent = 1'b1;
      pulse(r);
      chk("credit after cell", 32'h0000_0000, {22'h0, view.credits});
      r = '0;
      r.credit_valid = 1'b1;
      r.credit_add = 10'h3FF;
      r.frame_diff = 6'h05;
      pulse(r);
      chk("credit add", 32'h0000_03FF, {22'h0, view.credits});
      chk("eighths", 32'h0000_0002, {29'h0, view.mf_eighths});
      rd_chk("credit word", OFS_CREDIT, 32'h0000_43FF);
      r.credit_add = 10'h001;
      r.frame_diff = 6'h03;
      pulse(r);
      chk("credit clamp", 32'h0000_03FF, {22'h0, view.credits});
      chk("eighths carry", 32'h0000_0002, {29'h0, view.mf_eighths});
      chk("remainder", 32'h0000_0000, {30'h0, view.remainder});
      wr(OFS_MODE, 32'h0000_0003);
      r = '0;
      r.cell_sent = 1'b1;
      pulse(r);
      chk("credit high speed", 32'h0000_0287, {22'h0, view.credits});
   endtask : t_credits

   task automatic t_modes();
      logic [5:0] exp;
      for (int m = 0; m < 4; m++) begin
         wr(OFS_MODE, m);
         exp = (m >= 2) ? FULL_LINE_SLOTS : 6'h07;
         chk("slot count", {26'h0, exp}, {26'h0, view.slot_count});
         chk("avg payload", 32'h0000_0177, {22'h0, view.avg_payload});
      end
   endtask : t_modes

   task automatic t_bitmaps();
      sched_req_t r;
      // Sparse maps are only legal in the structured modes
      wr(OFS_MODE, 32'h0000_0000);
      wr(OFS_ALLOC_LOW, 32'h0000_0001);
      wr(OFS_ALLOC_HIGH, 32'h0000_8000);
      wr(OFS_LEFT_LOW, 32'h0000_0001);
      wr(OFS_LEFT_HIGH, 32'h0000_8000);
      chk("alloc map", 32'h8000_0001, view.alloc);
      chk("line", QN / 32, {29'h0, view.line});
      r = '0;
      r.byte_take = 1'b1;
      r.take_slot = 5'h1F;
      pulse(r);
      chk("left after take", 32'h0000_0001, view.left);
      r.take_slot = 5'h00;
      pulse(r);
      chk("left reloaded", 32'h8000_0001, view.left);
      rd_chk("left low", OFS_LEFT_LOW, 32'h0000_0001);
   endtask : t_bitmaps

   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      req = '0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset_unmapped();
      t_header();
      t_counter();
      t_credits();
      t_modes();
      t_bitmaps();
      stop_test();
   end

   // Counter wrap takes about 66k cycles; this leaves a margin
   initial begin
      #320000;
      miscompares++;
      stop_test();
   end
endmodule : tx_queue_state_table_tb
`default_nettype wire
